//--- rtl/pmic_pkg.sv
// Shared constants, register map and types of the power controller pin logic.
package pmic_pkg;
  localparam int NUM_PINS = 8;
  localparam int NUM_REGS = 4;
  localparam int TMR_W    = 20;
  localparam int SEQ_W    = 16;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef enum logic [4:0]
  {
    ST_STANDBY  = 5'h01,
    ST_PWR_UP   = 5'h02,
    ST_RST_WAIT = 5'h04,
    ST_ON       = 5'h08,
    ST_PWR_DN   = 5'h10
  } pwr_state_t;

  localparam logic [7:0] ADDR_DIR       = 8'h00;
  localparam logic [7:0] ADDR_DRV       = 8'h04;
  localparam logic [7:0] ADDR_DOUT      = 8'h08;
  localparam logic [7:0] ADDR_DBEN      = 8'h0c;
  localparam logic [7:0] ADDR_CFG       = 8'h10;
  localparam logic [7:0] ADDR_WAKE_EN   = 8'h14;
  localparam logic [7:0] ADDR_SHDN_INC  = 8'h18;
  localparam logic [7:0] ADDR_LEVEL     = 8'h1c;
  localparam logic [7:0] ADDR_RISE_FLAG = 8'h20;
  localparam logic [7:0] ADDR_FALL_FLAG = 8'h24;
  localparam logic [7:0] ADDR_RISE_MASK = 8'h28;
  localparam logic [7:0] ADDR_FALL_MASK = 8'h2c;
  localparam logic [7:0] ADDR_STATUS    = 8'h30;

  localparam logic [7:0] DIR_RST     = 8'hff;
  localparam logic [7:0] ZERO_RST    = 8'h00;
  localparam logic [7:0] WAKE_EN_RST = 8'hff;
  localparam logic [7:0] SHDN_RST    = 8'h05;
  localparam logic [7:0] MASK_RST    = 8'hff;
  localparam logic [7:0] LEVEL_RST   = 8'hff;

  localparam int CFG_DBSEL_LSB   = 0;
  localparam int CFG_SWTYPE_BIT  = 2;
  localparam int CFG_SOFTOFF_BIT = 3;

  localparam int CLK_PERIOD_NS             = 10;
  localparam int DEB_BASE_TIME_US          = 1250;
  localparam int DEB_TICK_CYCLES           = DEB_BASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int MANUAL_RESET_HOLD_TIME_MS = 16000;
  localparam int MR_HOLD_TICKS             = MANUAL_RESET_HOLD_TIME_MS * 1000 / DEB_BASE_TIME_US;
  localparam int PIN_SHUTDOWN_HOLD_TIME_MS = 8000;
  localparam int PIN_SHDN_TICKS            = PIN_SHUTDOWN_HOLD_TIME_MS * 1000 / DEB_BASE_TIME_US;
  localparam int REG_SEQ_STEP_NS           = 1000;
  localparam int RESET_RELEASE_DELAY_NS    = 10000;
  localparam int RESET_ASSERT_LEAD_NS      = 10000;
  localparam int SEQ_STEP_CYCLES = (REG_SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYCLES  = (RESET_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_CYCLES     = (RESET_ASSERT_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- rtl/input_debounce.sv
// Per-pin debounce filter counted in ticks of the gated debounce oscillator.
`timescale 1ns/10ps
`default_nettype none
module input_debounce
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       raw,
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic [3:0] period_ticks,
  output var  logic       level,
  output var  logic       busy
);
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic       level_ff;
  logic       nxt_level;
  logic       differs;
  logic       expired;

  assign differs = raw != level_ff;
  assign expired = tick && (cnt_ff + 4'h1 >= period_ticks);
  assign nxt_level = !enable ? raw : ((differs && expired) ? raw : level_ff);
  assign nxt_cnt   = (!enable || !differs || expired) ? 4'h0 : (tick ? cnt_ff + 4'h1 : cnt_ff);
  assign busy  = enable && differs;
  assign level = level_ff;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_ff   <= 4'h0;
      level_ff <= 1'b1;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      level_ff <= nxt_level;
    end
  end
endmodule
`default_nettype wire

//--- rtl/tick_hold_timer.sv
// Hold timer that measures how long a condition stays true in oscillator ticks.
`timescale 1ns/10ps
`default_nettype none
module tick_hold_timer
(
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     cond,
  input  wire logic                     tick,
  input  wire logic [pmic_pkg::TMR_W-1:0] limit,
  output var  logic                     done,
  output var  logic                     busy
);
  logic [pmic_pkg::TMR_W-1:0] cnt_ff;
  logic [pmic_pkg::TMR_W-1:0] nxt_cnt;

  assign nxt_cnt = !cond ? '0 : ((tick && !done) ? cnt_ff + 1'b1 : cnt_ff);
  assign done    = cond && (cnt_ff >= limit);
  // Once the interval is met the oscillator is no longer needed.
  assign busy    = cond && !done;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule
`default_nettype wire

//--- rtl/pmic_pin_ctrl.sv
// Pin, wake, shutdown, interrupt and reset-output logic of the power controller.
// Functional notes
// - On-key defaults to push-button; 1 selects slide
// - Interrupt pin low when any unmasked flag
// - All masks set after reset
// - Release reset after last regulator plus delay
// - Assert reset a lead before regulators drop
// - Direction 0 drives pin, 1 makes input
// - Drive type 1 push-pull, 0 open-drain
// - Input level reflects pin regardless of direction
// - Per-pin debounce, enable, 1.25/2.5/5/10 ms
// - Debounce oscillator runs only while counting
// - Separate maskable rise and fall flags
// - Wake-enabled input held low wakes device
// - Cleared wake enable ignores the pin
// - Wake enables and directions reset to one
// - Two included inputs low for hold shut down
// - Excluded inputs never count toward shutdown
// - Only pins 0 and 2 included after reset
// - On-key fall or pin wake starts power-up
// - Pin hold, on-key hold or soft-off to standby
// - Manual-reset level depends on switch type
// - Debounced pin wake leaves standby
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module pmic_pin_ctrl
#(
  parameter int TICK_CYCLES    = pmic_pkg::DEB_TICK_CYCLES,
  parameter int MR_TICKS       = pmic_pkg::MR_HOLD_TICKS,
  parameter int PIN_SHDN_TICKS = pmic_pkg::PIN_SHDN_TICKS
)
(
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  input  wire pmic_pkg::bus_req_t             bus_req,
  output var  logic [7:0]                     bus_rdata,
  input  wire logic [pmic_pkg::NUM_PINS-1:0]  pin_in,
  output var  logic [pmic_pkg::NUM_PINS-1:0]  pin_out,
  output var  logic [pmic_pkg::NUM_PINS-1:0]  pin_oe_n,
  input  wire logic                           on_key_input,
  output var  logic                           irq_out_n_out,
  output var  logic                           irq_out_n_oe_n,
  output var  logic                           reset_out_n_out,
  output var  logic                           reset_out_n_oe_n,
  output var  logic [pmic_pkg::NUM_REGS-1:0]  regulator_en,
  output var  logic                           debounce_osc_run
);
  localparam int NP = pmic_pkg::NUM_PINS;
  localparam int NR = pmic_pkg::NUM_REGS;

  logic [NP-1:0] dir_ff;
  logic [NP-1:0] drv_ff;
  logic [NP-1:0] dout_ff;
  logic [NP-1:0] dben_ff;
  logic [NP-1:0] wake_en_ff;
  logic [NP-1:0] shdn_inc_ff;
  logic [NP-1:0] rise_flag_ff;
  logic [NP-1:0] fall_flag_ff;
  logic [NP-1:0] rise_mask_ff;
  logic [NP-1:0] fall_mask_ff;
  logic [1:0]    dbsel_ff;
  logic          on_key_switch_type_ff;
  logic [7:0]    rdata_ff;
  logic [7:0]    nxt_rdata;

  logic [NP-1:0] input_level;
  logic [NP-1:0] level_prev_ff;
  logic [NP-1:0] deb_busy;
  logic [NP-1:0] rise_evt;
  logic [NP-1:0] fall_evt;
  logic [3:0]    period_ticks;

  logic [31:0]   div_ff;
  logic          tick;
  logic          osc_run;

  pmic_pkg::pwr_state_t state_ff;
  pmic_pkg::pwr_state_t nxt_state;
  logic [pmic_pkg::SEQ_W-1:0] seq_cnt_ff;
  logic [pmic_pkg::SEQ_W-1:0] nxt_seq_cnt;
  logic [2:0]    reg_idx_ff;
  logic [2:0]    nxt_reg_idx;
  logic [NR-1:0] reg_en_ff;
  logic [NR-1:0] nxt_reg_en;
  logic          rst_out_ff;
  logic          nxt_rst_out;
  logic          key_prev_ff;

  // Address decode and strobes.
  wire wr_dir   = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_DIR);
  wire wr_drv   = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_DRV);
  wire wr_dout  = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_DOUT);
  wire wr_dben  = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_DBEN);
  wire wr_cfg   = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_CFG);
  wire wr_wake  = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_WAKE_EN);
  wire wr_shdn  = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_SHDN_INC);
  wire wr_rflag = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_RISE_FLAG);
  wire wr_fflag = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_FALL_FLAG);
  wire wr_rmask = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_RISE_MASK);
  wire wr_fmask = bus_req.wr && (bus_req.addr == pmic_pkg::ADDR_FALL_MASK);
  wire soft_off_command = wr_cfg && bus_req.wdata[pmic_pkg::CFG_SOFTOFF_BIT];

  // Register writes; reset values give inputs, wake sources and full masking.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dir_ff                <= pmic_pkg::DIR_RST;
      wake_en_ff            <= pmic_pkg::WAKE_EN_RST;
      shdn_inc_ff           <= pmic_pkg::SHDN_RST;
      rise_mask_ff          <= pmic_pkg::MASK_RST;
      fall_mask_ff          <= pmic_pkg::MASK_RST;
      drv_ff                <= pmic_pkg::ZERO_RST;
      dout_ff               <= pmic_pkg::ZERO_RST;
      dben_ff               <= pmic_pkg::ZERO_RST;
      dbsel_ff              <= 2'h0;
      on_key_switch_type_ff <= 1'b0;
    end
    else
    begin
      if (wr_dir)
        dir_ff <= bus_req.wdata;
      if (wr_drv)
        drv_ff <= bus_req.wdata;
      if (wr_dout)
        dout_ff <= bus_req.wdata;
      if (wr_dben)
        dben_ff <= bus_req.wdata;
      if (wr_wake)
        wake_en_ff <= bus_req.wdata;
      if (wr_shdn)
        shdn_inc_ff <= bus_req.wdata;
      if (wr_rmask)
        rise_mask_ff <= bus_req.wdata;
      if (wr_fmask)
        fall_mask_ff <= bus_req.wdata;
      if (wr_cfg)
      begin
        dbsel_ff              <= bus_req.wdata[pmic_pkg::CFG_DBSEL_LSB +: 2];
        on_key_switch_type_ff <= bus_req.wdata[pmic_pkg::CFG_SWTYPE_BIT];
      end
    end
  end

  // Edge flags clear by writing one; a new edge in the same cycle wins.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rise_flag_ff  <= pmic_pkg::ZERO_RST;
      fall_flag_ff  <= pmic_pkg::ZERO_RST;
      level_prev_ff <= pmic_pkg::LEVEL_RST;
    end
    else
    begin
      rise_flag_ff  <= (rise_flag_ff & ~(wr_rflag ? bus_req.wdata : 8'h00)) | rise_evt;
      fall_flag_ff  <= (fall_flag_ff & ~(wr_fflag ? bus_req.wdata : 8'h00)) | fall_evt;
      level_prev_ff <= input_level;
    end
  end

  assign rise_evt = input_level & ~level_prev_ff;
  assign fall_evt = ~input_level & level_prev_ff;

  // Read path: data stand in the cycle after the strobe only.
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        pmic_pkg::ADDR_DIR:       nxt_rdata = dir_ff;
        pmic_pkg::ADDR_DRV:       nxt_rdata = drv_ff;
        pmic_pkg::ADDR_DOUT:      nxt_rdata = dout_ff;
        pmic_pkg::ADDR_DBEN:      nxt_rdata = dben_ff;
        pmic_pkg::ADDR_CFG:       nxt_rdata = {5'h00, on_key_switch_type_ff, dbsel_ff};
        pmic_pkg::ADDR_WAKE_EN:   nxt_rdata = wake_en_ff;
        pmic_pkg::ADDR_SHDN_INC:  nxt_rdata = shdn_inc_ff;
        pmic_pkg::ADDR_LEVEL:     nxt_rdata = input_level;
        pmic_pkg::ADDR_RISE_FLAG: nxt_rdata = rise_flag_ff;
        pmic_pkg::ADDR_FALL_FLAG: nxt_rdata = fall_flag_ff;
        pmic_pkg::ADDR_RISE_MASK: nxt_rdata = rise_mask_ff;
        pmic_pkg::ADDR_FALL_MASK: nxt_rdata = fall_mask_ff;
        pmic_pkg::ADDR_STATUS:    nxt_rdata = {2'h0, rst_out_ff, state_ff};
        default:                  nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign bus_rdata = rdata_ff;

  assign pin_oe_n = ~(~dir_ff & (drv_ff | ~dout_ff));
  assign pin_out  = dout_ff & drv_ff;

  // Gated oscillator: the divider holds at zero unless a timer is counting.
  wire mr_busy;
  wire mr_done;
  wire ps_busy;
  wire ps_done;
  assign osc_run = (|deb_busy) || mr_busy || ps_busy;
  assign tick    = osc_run && (div_ff == 32'(TICK_CYCLES - 1));
  assign debounce_osc_run = osc_run;

  always_ff @(posedge clk)
  begin
    if (!reset_n || !osc_run || tick)
      div_ff <= 32'h0;
    else
      div_ff <= div_ff + 32'h1;
  end

  // Period is one to eight ticks
  assign period_ticks = 4'h1 << dbsel_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_pin
      input_debounce u_deb
      (
        .clk          (clk),
        .reset_n      (reset_n),
        .raw          (pin_in[gi]),
        .enable       (dben_ff[gi]),
        .tick         (tick),
        .period_ticks (period_ticks),
        .level        (input_level[gi]),
        .busy         (deb_busy[gi])
      );
    end
  endgenerate

  wire irq_any = |((rise_flag_ff & ~rise_mask_ff) | (fall_flag_ff & ~fall_mask_ff));
  assign irq_out_n_out  = 1'b0;
  assign irq_out_n_oe_n = ~irq_any;

  wire pin_wake = |(~input_level & wake_en_ff & dir_ff);

  wire [NP-1:0] shdn_low = ~input_level & shdn_inc_ff & dir_ff;
  wire          shdn_pair = |(shdn_low & (shdn_low - 8'h01));

  tick_hold_timer u_pin_shdn
  (
    .clk     (clk),
    .reset_n (reset_n),
    .cond    (shdn_pair && (state_ff == pmic_pkg::ST_ON)),
    .tick    (tick),
    .limit   (pmic_pkg::TMR_W'(PIN_SHDN_TICKS)),
    .done    (ps_done),
    .busy    (ps_busy)
  );

  wire key_hold_level = on_key_switch_type_ff ? on_key_input : ~on_key_input;

  tick_hold_timer u_man_rst
  (
    .clk     (clk),
    .reset_n (reset_n),
    .cond    (key_hold_level && (state_ff == pmic_pkg::ST_ON)),
    .tick    (tick),
    .limit   (pmic_pkg::TMR_W'(MR_TICKS)),
    .done    (mr_done),
    .busy    (mr_busy)
  );

  wire key_fall  = key_prev_ff && !on_key_input;
  wire seq_done  = seq_cnt_ff == pmic_pkg::SEQ_W'(pmic_pkg::SEQ_STEP_CYCLES - 1);
  wire rel_done  = seq_cnt_ff == pmic_pkg::SEQ_W'(pmic_pkg::RELEASE_CYCLES - 1);
  wire lead_done = seq_cnt_ff == pmic_pkg::SEQ_W'(pmic_pkg::LEAD_CYCLES - 1);
  wire last_reg  = reg_idx_ff == 3'(NR - 1);
  // Power-down clears one enable per cycle, from the last regulator back to the first.

  // Power sequencing: regulators step up in order and down in reverse.
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_seq_cnt = seq_cnt_ff + pmic_pkg::SEQ_W'(1);
    nxt_reg_idx = reg_idx_ff;
    nxt_reg_en  = reg_en_ff;
    nxt_rst_out = rst_out_ff;
    unique case (state_ff)
      pmic_pkg::ST_STANDBY:
      begin
        nxt_seq_cnt = '0;
        if (key_fall || pin_wake)
        begin
          nxt_state   = pmic_pkg::ST_PWR_UP;
          nxt_reg_idx = 3'h0;
        end
      end
      pmic_pkg::ST_PWR_UP:
      begin
        if (seq_done)
        begin
          nxt_seq_cnt = '0;
          nxt_reg_en[reg_idx_ff[1:0]] = 1'b1;
          nxt_reg_idx = reg_idx_ff + 3'h1;
          if (last_reg)
            nxt_state = pmic_pkg::ST_RST_WAIT;
        end
      end
      pmic_pkg::ST_RST_WAIT:
      begin
        if (rel_done)
        begin
          nxt_rst_out = 1'b1;
          nxt_state   = pmic_pkg::ST_ON;
        end
      end
      pmic_pkg::ST_ON:
      begin
        nxt_seq_cnt = '0;
        if (ps_done || mr_done || soft_off_command)
        begin
          nxt_rst_out = 1'b0;
          nxt_reg_idx = 3'(NR - 1);
          nxt_state   = pmic_pkg::ST_PWR_DN;
        end
      end
      pmic_pkg::ST_PWR_DN:
      begin
        if (lead_done || (seq_cnt_ff == pmic_pkg::SEQ_W'(pmic_pkg::LEAD_CYCLES)))
        begin
          nxt_seq_cnt = pmic_pkg::SEQ_W'(pmic_pkg::LEAD_CYCLES);
          nxt_reg_en[reg_idx_ff[1:0]] = 1'b0;
          nxt_reg_idx = reg_idx_ff - 3'h1;
          if (reg_idx_ff == 3'h0)
          begin
            nxt_seq_cnt = '0;
            nxt_state   = pmic_pkg::ST_STANDBY;
          end
        end
      end
      default:
      begin
        nxt_state   = pmic_pkg::ST_STANDBY;
        nxt_reg_en  = '0;
        nxt_rst_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_ff    <= pmic_pkg::ST_STANDBY;
      seq_cnt_ff  <= '0;
      reg_idx_ff  <= 3'h0;
      reg_en_ff   <= '0;
      rst_out_ff  <= 1'b0;
      key_prev_ff <= 1'b1;
    end
    else
    begin
      state_ff    <= nxt_state;
      seq_cnt_ff  <= nxt_seq_cnt;
      reg_idx_ff  <= nxt_reg_idx;
      reg_en_ff   <= nxt_reg_en;
      rst_out_ff  <= nxt_rst_out;
      key_prev_ff <= on_key_input;
    end
  end

  assign regulator_en     = reg_en_ff;
  assign reset_out_n_out  = 1'b0;
  // The reset pin is open-drain: released means the driver is off.
  assign reset_out_n_oe_n = rst_out_ff;
endmodule
`default_nettype wire

//--- testbench/pmic_pin_ctrl_assertions.sv
// Port checker of the power controller pin logic.
`timescale 1ns/10ps
`default_nettype none
module pmic_pin_ctrl_checker
(
  input wire logic               clk,
  input wire logic               reset_n,
  input wire pmic_pkg::bus_req_t bus_req,
  input wire logic [7:0]         bus_rdata,
  input wire logic [7:0]         pin_in,
  input wire logic [7:0]         pin_out,
  input wire logic [7:0]         pin_oe_n,
  input wire logic               on_key_input,
  input wire logic               irq_out_n_out,
  input wire logic               irq_out_n_oe_n,
  input wire logic               reset_out_n_out,
  input wire logic               reset_out_n_oe_n,
  input wire logic [3:0]         regulator_en,
  input wire logic               debounce_osc_run
);
  logic [7:0]  dir_ff;
  logic [7:0]  drv_ff;
  logic [7:0]  dout_ff;
  logic [7:0]  rmask_ff;
  logic [7:0]  fmask_ff;
  logic [11:0] full_cnt_ff;

  // Shadow copies of the direction, drive, output and mask registers, kept from the bus alone.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dir_ff   <= 8'hff;
      drv_ff   <= 8'h00;
      dout_ff  <= 8'h00;
      rmask_ff <= 8'hff;
      fmask_ff <= 8'hff;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == pmic_pkg::ADDR_DIR)
        dir_ff <= bus_req.wdata;
      if (bus_req.addr == pmic_pkg::ADDR_DRV)
        drv_ff <= bus_req.wdata;
      if (bus_req.addr == pmic_pkg::ADDR_DOUT)
        dout_ff <= bus_req.wdata;
      if (bus_req.addr == pmic_pkg::ADDR_RISE_MASK)
        rmask_ff <= bus_req.wdata;
      if (bus_req.addr == pmic_pkg::ADDR_FALL_MASK)
        fmask_ff <= bus_req.wdata;
    end
  end

  // Cycles with all regulators on while reset is held; one counter serves both sequencing edges.
  always_ff @(posedge clk)
  begin
    if (!reset_n || reset_out_n_oe_n || regulator_en != 4'hf)
      full_cnt_ff <= 12'h000;
    else
      full_cnt_ff <= full_cnt_ff + 12'h001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  irq_masked_a : assert property (
    (rmask_ff & fmask_ff) == 8'hff |-> irq_out_n_oe_n && !irq_out_n_out)
    else $error("interrupt output low with all flags masked");
  reset_state_a : assert property (
    $rose(reset_n) |-> pin_oe_n == 8'hff && irq_out_n_oe_n && regulator_en == 4'h0)
    else $error("outputs not at their reset state");
  dir_input_a : assert property (
    &(pin_oe_n | ~dir_ff))
    else $error("input pin is driven");
  drive_kind_a : assert property (
    &(dir_ff | (drv_ff & ~pin_oe_n & ~(pin_out ^ dout_ff)) | (~drv_ff & ~pin_out & ~(pin_oe_n ^ dout_ff))))
    else $error("pin drive does not follow drive type");
  release_delay_a : assert property (
    $rose(reset_out_n_oe_n) |-> regulator_en == 4'hf && full_cnt_ff >= 12'(pmic_pkg::RELEASE_CYCLES - 2)
      && full_cnt_ff <= 12'(pmic_pkg::RELEASE_CYCLES + 2))
    else $error("reset released at the wrong time");
  assert_lead_a : assert property (
    $fell(regulator_en[3]) |-> !reset_out_n_oe_n && full_cnt_ff >= 12'(pmic_pkg::LEAD_CYCLES - 2)
      && full_cnt_ff <= 12'(pmic_pkg::LEAD_CYCLES + 2))
    else $error("regulator dropped without reset lead");
  reg_order_a : assert property (
    regulator_en inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("regulators out of order");
  reset_low_a : assert property (
    regulator_en != 4'hf |-> !reset_out_n_oe_n && !reset_out_n_out)
    else $error("reset released with a regulator off");
endmodule

bind pmic_pin_ctrl pmic_pin_ctrl_checker i_checker
(
  .clk(clk),
  .reset_n(reset_n),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .pin_in(pin_in),
  .pin_out(pin_out),
  .pin_oe_n(pin_oe_n),
  .on_key_input(on_key_input),
  .irq_out_n_out(irq_out_n_out),
  .irq_out_n_oe_n(irq_out_n_oe_n),
  .reset_out_n_out(reset_out_n_out),
  .reset_out_n_oe_n(reset_out_n_oe_n),
  .regulator_en(regulator_en),
  .debounce_osc_run(debounce_osc_run)
);
`default_nettype wire

//--- testbench/pin_side_model.sv
// Pin-side model: pull-ups and switches on the eight pins.
`timescale 1ns/10ps
`default_nettype none
module pin_side_model
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ext_low,
  output var  logic [7:0] pin_in
);
  // pull-up and switch
  // A released pin floats to the pull-up; a closed switch wins over any driver.
  always_comb
    pin_in = ~ext_low & (pin_oe_n | pin_out);
endmodule
`default_nettype wire

//--- testbench/pmic_pin_ctrl_tb.sv
// Self-checking bench of the pin controller with a pin-side model.
`timescale 1ns/10ps
`default_nettype none
module pmic_pin_ctrl_tb;
  localparam int TK = 4;
  logic               clk;
  logic               reset_n;
  pmic_pkg::bus_req_t req;
  logic [7:0]         rdata;
  logic [7:0]         pin_in;
  logic [7:0]         pin_out;
  logic [7:0]         pin_oe_n;
  logic [7:0]         ext_low;
  logic               on_key;
  logic               irq_oe_n;
  logic [3:0]         reg_en;
  logic               osc_run;
  int                 err_total;
  int                 total_checks;

  pmic_pin_ctrl #(.TICK_CYCLES(TK), .MR_TICKS(20), .PIN_SHDN_TICKS(10)) i_dut
  (
    .clk(clk),
    .reset_n(reset_n),
    .bus_req(req),
    .bus_rdata(rdata),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .on_key_input(on_key),
    .irq_out_n_out(),
    .irq_out_n_oe_n(irq_oe_n),
    .reset_out_n_out(),
    .reset_out_n_oe_n(),
    .regulator_en(reg_en),
    .debounce_osc_run(osc_run)
  );

  pin_side_model i_pins
  (
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .ext_low(ext_low),
    .pin_in(pin_in)
  );

  task automatic complete_run;
  begin
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  end
  endtask

  // Every access starts on a fresh edge, so req is never assigned twice in one step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
  begin
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1 q = rdata;
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
  begin
    bus(1'b1, a, d, q);
  end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
  begin
    bus(1'b0, a, 8'h00, q);
    chk(q, exp);
  end
  endtask

  task automatic step(input int n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask

  task automatic wait_st(input logic [7:0] exp, input int lim);
    logic [7:0] q;
  begin
    q = 8'h00;
    for (int i = 0; i < lim && q !== exp; i++)
      bus(1'b0, pmic_pkg::ADDR_STATUS, 8'h00, q);
    chk(q, exp);
  end
  endtask

  task automatic key_on;
  begin
    @(posedge clk) on_key <= 1'b0;
    step(3);
    @(posedge clk) on_key <= 1'b1;
    wait_st(8'h28, 1000);
  end
  endtask

  task automatic t_reset;
    logic [7:0] a [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h28, 8'h2c, 8'h3c, 8'h30};
    logic [7:0] e [11] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h05, 8'hff, 8'hff, 8'h00, 8'h01};
  begin
    for (int i = 0; i < 11; i++)
      rd(a[i], e[i]);
  end
  endtask

  task automatic t_pins;
  begin
    wr(8'h14, 8'h00);
    wr(8'h00, 8'hf0);
    wr(8'h04, 8'h05);
    wr(8'h08, 8'h03);
    @(posedge clk) ext_low <= 8'h40;
    step(3);
    chk(pin_oe_n, 8'hf2);
    chk(pin_out, 8'h01);
    rd(8'h1c, 8'hb3);
    rd(8'h30, 8'h01);
    wr(8'h00, 8'hff);
    @(posedge clk) ext_low <= 8'h00;
    step(3);
    chk(pin_oe_n, 8'hff);
  end
  endtask

  task automatic t_irq;
  begin
    wr(8'h20, 8'hff);
    wr(8'h24, 8'hff);
    wr(8'h2c, 8'hdf);
    chk({7'h0, irq_oe_n}, 8'h01);
    @(posedge clk) ext_low <= 8'h20;
    step(4);
    chk({7'h0, irq_oe_n}, 8'h00);
    rd(8'h24, 8'h20);
    @(posedge clk) ext_low <= 8'h00;
    step(4);
    rd(8'h20, 8'h20);
    wr(8'h24, 8'h20);
    chk({7'h0, irq_oe_n}, 8'h01);
    wr(8'h28, 8'hdf);
    chk({7'h0, irq_oe_n}, 8'h00);
    wr(8'h20, 8'h20);
    chk({7'h0, irq_oe_n}, 8'h01);
    wr(8'h2c, 8'hff);
    wr(8'h28, 8'hff);
  end
  endtask

  task automatic t_deb;
    int n;
  begin
    wr(8'h0c, 8'h40);
    wr(8'h10, 8'h03);
    @(posedge clk) ext_low <= 8'h40;
    @(posedge clk) ext_low <= 8'h00;
    step(40);
    rd(8'h1c, 8'hff);
    chk({7'h0, osc_run}, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      n = TK << s;
      wr(8'h10, 8'(s));
      @(posedge clk) ext_low <= 8'h40;
      step(n - 2);
      chk({7'h0, osc_run}, 8'h01);
      rd(8'h1c, 8'hff);
      step(8);
      rd(8'h1c, 8'hbf);
      chk({7'h0, osc_run}, 8'h00);
      @(posedge clk) ext_low <= 8'h00;
      step(n + 10);
    end
    wr(8'h0c, 8'h00);
  end
  endtask

  task automatic t_wake_off;
  begin
    wr(8'h14, 8'h10);
    @(posedge clk) ext_low <= 8'h10;
    wait_st(8'h28, 1000);
    chk({4'h0, reg_en}, 8'h0f);
    wr(8'h14, 8'h00);
    @(posedge clk) ext_low <= 8'h0a;
    step(200);
    rd(8'h30, 8'h28);
    @(posedge clk) ext_low <= 8'h05;
    step(30);
    rd(8'h30, 8'h28);
    wait_st(8'h01, 1000);
    @(posedge clk) ext_low <= 8'h00;
  end
  endtask

  task automatic t_key;
  begin
    key_on();
    wr(8'h10, 8'h08);
    wait_st(8'h01, 1000);
    key_on();
    @(posedge clk) on_key <= 1'b0;
    wait_st(8'h01, 1000);
    @(posedge clk) on_key <= 1'b1;
    wr(8'h10, 8'h04);
    rd(8'h10, 8'h04);
    @(posedge clk) on_key <= 1'b0;
    wait_st(8'h28, 1000);
    @(posedge clk) on_key <= 1'b1;
    wait_st(8'h01, 1000);
    wr(8'h10, 8'h00);
  end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial
  begin
    reset_n = 1'b0;
    req = '0;
    ext_low = 8'h00;
    on_key = 1'b1;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_pins();
    t_irq();
    t_deb();
    t_wake_off();
    t_key();
    complete_run();
  end
endmodule
`default_nettype wire
